//--- core/sic_pkg.sv
// constants, types and helpers shared by the safe input conditioner
package sic_pkg;

	// ************************************************
	// timing
	// ************************************************
	localparam int SIC_CLK_NS = 25;
	localparam int SIC_TICK_US = 400;
	localparam int SIC_TICK_CYCLES = (SIC_TICK_US * 1000) / SIC_CLK_NS;
	localparam int SIC_BASIC_US = 1200;
	localparam int SIC_BASIC_TICKS = (SIC_BASIC_US + SIC_TICK_US - 1) / SIC_TICK_US;
	localparam int SIC_TP_MAX_US = 2000000;
	localparam int SIC_TP_TICKS = SIC_TP_MAX_US / SIC_TICK_US;

	// ************************************************
	// sizes and register map
	// ************************************************
	localparam int SIC_LINES = 6;
	localparam int SIC_GROUPS = 3;
	localparam logic [7:0] SIC_ADR_CFG0 = 8'h00;
	localparam logic [7:0] SIC_ADR_CFG1 = 8'h04;
	localparam logic [7:0] SIC_ADR_CFG2 = 8'h08;
	localparam logic [7:0] SIC_ADR_CRC = 8'h0c;
	localparam logic [7:0] SIC_ADR_CTRL = 8'h10;
	localparam logic [7:0] SIC_ADR_STAT = 8'h14;
	localparam logic [7:0] SIC_ADR_ACT0 = 8'h18;
	localparam logic [7:0] SIC_ADR_ACT1 = 8'h1c;
	localparam logic [7:0] SIC_ADR_ACT2 = 8'h20;
	localparam int SIC_CTRL_COMMIT = 0;
	localparam int SIC_CTRL_ERRCLR = 1;
	localparam int SIC_ST_VAL_LSB = 0;
	localparam int SIC_ST_CERR_LSB = 6;
	localparam int SIC_ST_TERR_LSB = 9;
	localparam int SIC_ST_CRCERR = 15;
	localparam int SIC_ST_APPLIED = 16;
	localparam logic [15:0] SIC_CRC_POLY = 16'h1021;
	localparam logic [15:0] SIC_CRC_INIT = 16'hffff;

	// ************************************************
	// encodings and types
	// ************************************************
	localparam logic SIC_TYPE_SEMI = 1'b0;
	localparam logic SIC_TYPE_CONTACT = 1'b1;
	localparam logic SIC_MODE_SINGLE = 1'b0;
	localparam logic SIC_MODE_DUAL = 1'b1;
	localparam logic SIC_RST_MANUAL = 1'b0;

	typedef struct packed {
		logic [15:0] cons;
		logic [7:0] deb;
		logic [3:0] rsvd;
		logic rst_type;
		logic mode;
		logic in_type;
		logic en;
	} sic_grp_cfg_t;

	typedef struct packed {
		logic level;
		logic [8:0] cnt;
		logic [12:0] tp_cnt;
		logic tp_err;
	} sic_flt_st_t;

	typedef struct packed {
		logic [15:0] dif_cnt;
		logic [15:0] eq_cnt;
		logic err;
		logic comb;
	} sic_con_st_t;

	typedef struct packed {
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic [15:0] tick_cnt;
		logic tick;
		sic_grp_cfg_t [2:0] shadow;
		sic_grp_cfg_t [2:0] active;
		logic [15:0] crc;
		logic crc_err;
		logic applied;
		logic clr;
		logic [5:0] val;
		logic [31:0] rdata;
	} sic_top_st_t;

	localparam sic_flt_st_t SIC_FLT_RST = '0;
	localparam sic_con_st_t SIC_CON_RST = '0;
	localparam sic_top_st_t SIC_TOP_RST = '0;

	// crc over the three configuration words, msb of word 2 first
	function automatic logic [15:0] sic_crc16(input logic [95:0] d);
		logic [15:0] c;
		c = SIC_CRC_INIT;
		for (int i = 95; i >= 0; i--) begin
			c = {c[14:0], 1'b0} ^ (((c[15] ^ d[i]) == 1'b1) ? SIC_CRC_POLY : 16'h0000);
		end
		return c;
	endfunction

endpackage

//--- core/sic_line_flt.sv
// debounce and test pulse supervision for one safe input line
`timescale 1ns/1ps
module sic_line_flt import sic_pkg::*; #(
	parameter int TP_TICKS = SIC_TP_TICKS
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic in_i,
	input wire logic contact_i,
	input wire logic [7:0] deb_i,
	input wire logic clr_i,
	output logic level_o,
	output logic tp_err_o
);

	localparam logic [12:0] TP_MAX = 13'(TP_TICKS);

	if (TP_TICKS < 1 || TP_TICKS > 8191) begin : g_chk
		$error("TP_TICKS out of range");
	end

	sic_flt_st_t s;
	sic_flt_st_t n;
	logic [8:0] tgt;

	// ************************************************
	// filter
	// ************************************************
	always_comb begin
		n = s;
		if (s.level) begin
			tgt = {1'b0, deb_i};
		end else begin
			tgt = 9'({1'b0, deb_i} + 9'(SIC_BASIC_TICKS));
		end
		if (in_i == s.level) begin
			n.cnt = '0;
		end else if (tick_i) begin
			if (s.cnt >= tgt) begin
				n.level = in_i;
				n.cnt = '0;
			end else begin
				n.cnt = 9'(s.cnt + 9'h001);
			end
		end
		if (clr_i) begin
			n.tp_err = 1'b0;
		end
		if (contact_i != SIC_TYPE_CONTACT || !in_i) begin
			n.tp_cnt = '0;
		end else if (tick_i) begin
			if (s.tp_cnt >= TP_MAX) begin
				n.tp_err = 1'b1;
			end else begin
				n.tp_cnt = 13'(s.tp_cnt + 13'h0001);
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s <= SIC_FLT_RST;
		end else begin
			s <= n;
		end
	end

	assign level_o = s.level;
	assign tp_err_o = s.tp_err;

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_change_on_tick: assert property ($changed(level_o) |-> $past(tick_i))
		else $error("level changed without tick");
	a_rise_needs_high: assert property ($rose(level_o) |-> $past(in_i))
		else $error("level rose while input low");
	a_tp_err_sticky: assert property (tp_err_o && !clr_i |=> tp_err_o)
		else $error("pulse error dropped without clear");

endmodule

//--- core/sic_con_flt.sv
// consistency supervision and combination of one dual-channel pair
`timescale 1ns/1ps
module sic_con_flt import sic_pkg::*; (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic a_i,
	input wire logic b_i,
	input wire logic dual_i,
	input wire logic [15:0] tc_i,
	input wire logic clr_i,
	output logic comb_o,
	output logic err_o
);

	sic_con_st_t s;
	sic_con_st_t n;

	// ************************************************
	// supervision
	// ************************************************
	always_comb begin
		n = s;
		if (dual_i != SIC_MODE_DUAL) begin
			n = SIC_CON_RST;
		end else begin
			if (clr_i) begin
				n.err = 1'b0;
			end
			if (a_i != b_i) begin
				n.eq_cnt = '0;
				if (tick_i && tc_i != 16'h0000) begin
					if (s.dif_cnt >= tc_i) begin
						n.err = 1'b1;
					end else begin
						n.dif_cnt = 16'(s.dif_cnt + 16'h0001);
					end
				end
			end else begin
				n.dif_cnt = '0;
				if (tick_i && s.eq_cnt < tc_i) begin
					n.eq_cnt = 16'(s.eq_cnt + 16'h0001);
				end
			end
			n.comb = a_i && b_i && (n.eq_cnt >= tc_i) && !n.err;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s <= SIC_CON_RST;
		end else begin
			s <= n;
		end
	end

	assign comb_o = s.comb;
	assign err_o = s.err;

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_err_sticky: assert property (err_o && dual_i && !clr_i |=> err_o)
		else $error("consistency error dropped without clear");
	a_single_idle: assert property (!dual_i |=> !err_o && !comb_o)
		else $error("supervision active in single mode");
	a_comb_both: assert property (comb_o |-> $past(a_i && b_i) && !err_o)
		else $error("combined high without both lines");

endmodule

//--- core/sic_top.sv
// safe input conditioner: sync, enable, filters, pairing and config registers
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

module sic_top import sic_pkg::*; #(
	parameter int TICK_CYCLES = SIC_TICK_CYCLES,
	parameter int TP_TICKS = SIC_TP_TICKS
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [5:0] safe_in_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic [5:0] safe_val_o,
	output logic [2:0] cons_err_o,
	output logic [5:0] line_err_o,
	output logic cfg_crc_err_o,
	output logic cfg_applied_o
);

	localparam logic [15:0] TCNT_MAX = 16'(TICK_CYCLES - 1);

	if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_chk
		$error("TICK_CYCLES out of range");
	end

	sic_top_st_t s;
	sic_top_st_t n;
	sic_grp_cfg_t cfg_wr;
	logic [15:0] crc_calc;
	logic crc_ok;
	logic [31:0] stat;
	logic [5:0] line_in;
	logic [5:0] lvl;
	logic [5:0] terr;
	logic [2:0] comb;
	logic [2:0] cerr;

	// ************************************************
	// write data and crc check
	// ************************************************
	always_comb begin
		cfg_wr = sic_grp_cfg_t'(reg_wdata_i);
		cfg_wr.rsvd = '0;
	end

	assign crc_calc = sic_crc16(s.shadow);
	assign crc_ok = (crc_calc == s.crc);

	// ************************************************
	// status word
	// ************************************************
	always_comb begin
		stat = '0;
		stat[SIC_ST_VAL_LSB +: SIC_LINES] = s.val;
		stat[SIC_ST_CERR_LSB +: SIC_GROUPS] = cerr;
		stat[SIC_ST_TERR_LSB +: SIC_LINES] = terr;
		stat[SIC_ST_CRCERR] = s.crc_err;
		stat[SIC_ST_APPLIED] = s.applied;
	end

	// ************************************************
	// line inputs after sync and enable
	// ************************************************
	always_comb begin
		for (int i = 0; i < SIC_LINES; i++) begin
			line_in[i] = s.sync2[i] & s.active[i / 2].en;
		end
	end

	// ************************************************
	// next state
	// ************************************************
	always_comb begin
		n = s;
		n.sync1 = safe_in_i;
		n.sync2 = s.sync1;
		n.tick = 1'b0;
		if (s.tick_cnt == TCNT_MAX) begin
			n.tick_cnt = '0;
			n.tick = 1'b1;
		end else begin
			n.tick_cnt = 16'(s.tick_cnt + 16'h0001);
		end
		n.clr = 1'b0;
		n.rdata = '0;
		if (reg_wr_i) begin
			case (reg_addr_i)
				SIC_ADR_CFG0: begin
					n.shadow[0] = cfg_wr;
				end
				SIC_ADR_CFG1: begin
					n.shadow[1] = cfg_wr;
				end
				SIC_ADR_CFG2: begin
					n.shadow[2] = cfg_wr;
				end
				SIC_ADR_CRC: begin
					n.crc = reg_wdata_i[15:0];
				end
				SIC_ADR_CTRL: begin
					if (reg_wdata_i[SIC_CTRL_COMMIT]) begin
						if (crc_ok) begin
							n.active = s.shadow;
							n.crc_err = 1'b0;
							n.applied = 1'b1;
						end else begin
							n.crc_err = 1'b1;
						end
					end
					if (reg_wdata_i[SIC_CTRL_ERRCLR]) begin
						n.clr = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				SIC_ADR_CFG0: begin
					n.rdata = s.shadow[0];
				end
				SIC_ADR_CFG1: begin
					n.rdata = s.shadow[1];
				end
				SIC_ADR_CFG2: begin
					n.rdata = s.shadow[2];
				end
				SIC_ADR_CRC: begin
					n.rdata = {16'h0000, s.crc};
				end
				SIC_ADR_STAT: begin
					n.rdata = stat;
				end
				SIC_ADR_ACT0: begin
					n.rdata = s.active[0];
				end
				SIC_ADR_ACT1: begin
					n.rdata = s.active[1];
				end
				SIC_ADR_ACT2: begin
					n.rdata = s.active[2];
				end
				default: begin
					n.rdata = '0;
				end
			endcase
		end
		for (int g = 0; g < SIC_GROUPS; g++) begin
			if (!s.active[g].en) begin
				n.val[2 * g +: 2] = 2'b00;
			end else if (s.active[g].mode == SIC_MODE_DUAL) begin
				n.val[2 * g] = comb[g] & ~(|terr[2 * g +: 2]);
				n.val[2 * g + 1] = comb[g] & ~(|terr[2 * g +: 2]);
			end else begin
				n.val[2 * g] = lvl[2 * g] & ~terr[2 * g];
				n.val[2 * g + 1] = lvl[2 * g + 1] & ~terr[2 * g + 1];
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s <= SIC_TOP_RST;
		end else begin
			s <= n;
		end
	end

	// ************************************************
	// line filters
	// ************************************************
	for (genvar i = 0; i < SIC_LINES; i++) begin : g_line
		sic_line_flt #(
			.TP_TICKS(TP_TICKS)
		) u_flt (
			.core_clk_i(core_clk_i),
			.rst_n_i(rst_n_i),
			.tick_i(s.tick),
			.in_i(line_in[i]),
			.contact_i(s.active[i / 2].in_type),
			.deb_i(s.active[i / 2].deb),
			.clr_i(s.clr),
			.level_o(lvl[i]),
			.tp_err_o(terr[i])
		);
	end

	// ************************************************
	// pair supervision on debounced levels
	// ************************************************
	for (genvar g = 0; g < SIC_GROUPS; g++) begin : g_grp
		sic_con_flt u_con (
			.core_clk_i(core_clk_i),
			.rst_n_i(rst_n_i),
			.tick_i(s.tick),
			.a_i(lvl[2 * g]),
			.b_i(lvl[2 * g + 1]),
			.dual_i(s.active[g].mode),
			.tc_i(s.active[g].cons),
			.clr_i(s.clr),
			.comb_o(comb[g]),
			.err_o(cerr[g])
		);
	end

	// ************************************************
	// outputs
	// ************************************************
	assign reg_rdata_o = s.rdata;
	assign safe_val_o = s.val;
	assign cons_err_o = cerr;
	assign line_err_o = terr;
	assign cfg_crc_err_o = s.crc_err;
	assign cfg_applied_o = s.applied;

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_commit;
		reg_wr_i && reg_addr_i == SIC_ADR_CTRL && reg_wdata_i[SIC_CTRL_COMMIT];
	endsequence

	sequence s_read(logic [7:0] adr);
		reg_rd_i && reg_addr_i == adr;
	endsequence

	a_commit_good: assert property (s_commit ##0 crc_ok |=>
		s.active == $past(s.shadow) && !cfg_crc_err_o && cfg_applied_o)
		else $error("matching crc did not apply config");
	a_commit_bad: assert property (s_commit ##0 !crc_ok |=>
		cfg_crc_err_o && $stable(s.active))
		else $error("bad crc changed config");
	a_tick_period: assert property ($rose(s.tick) |=> !s.tick)
		else $error("tick longer than one cycle");
	a_read_status: assert property (s_read(SIC_ADR_STAT) |=>
		reg_rdata_o[SIC_ST_CRCERR] == $past(s.crc_err))
		else $error("status read wrong");
	a_read_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
		else $error("read data without read");

	for (genvar g = 0; g < SIC_GROUPS; g++) begin : g_chk_grp
		a_disabled_low: assert property (!s.active[g].en |=>
			safe_val_o[2 * g +: 2] == 2'b00)
			else $error("disabled group not low");
		a_dual_pair: assert property (s.active[g].mode == SIC_MODE_DUAL |=>
			safe_val_o[2 * g] == safe_val_o[2 * g + 1])
			else $error("dual pair outputs differ");
		a_dual_err_low: assert property (s.active[g].mode == SIC_MODE_DUAL && cerr[g] |=>
			safe_val_o[2 * g +: 2] == 2'b00)
			else $error("dual error not safe");
	end

endmodule

//--- dv/sic_pin_model.sv
// pin-side model of the contacts and sensors wired to the safe inputs
`timescale 1ns/1ps
module sic_pin_model (
	input wire logic core_clk_i,
	input wire logic [5:0] lvl_i,
	input wire logic [5:0] tp_i,
	output logic [5:0] safe_in_o
);
	int ph = 0;
	initial begin
		safe_in_o = 6'h00;
	end
	// contacts on pulsed lines show a one-cycle low test pulse every 16 clocks
	always @(posedge core_clk_i) begin
		ph <= (ph + 1) % 16;
		safe_in_o <= (ph == 0) ? (lvl_i & ~tp_i) : lvl_i;
	end
endmodule

//--- dv/sic_top_tb.sv
// self-checking bench for the safe input conditioner
`timescale 1ns/1ps
module sic_top_tb import sic_pkg::*;;
	localparam int TK = 4;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic [5:0] safe_in_i;
	logic [5:0] safe_val_o;
	logic [5:0] line_err_o;
	logic [5:0] lvl = 6'h00;
	logic [5:0] tp = 6'h10;
	logic [2:0] cons_err_o;
	logic cfg_crc_err_o;
	logic cfg_applied_o;
	logic [31:0] cfg [3];
	logic [31:0] act [3];
	int miscompares = 0;
	int check_count = 0;

	always #12.5 core_clk_i = ~core_clk_i;

	sic_top #(.TICK_CYCLES(TK), .TP_TICKS(8)) DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.safe_in_i(safe_in_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.safe_val_o(safe_val_o), .cons_err_o(cons_err_o), .line_err_o(line_err_o),
		.cfg_crc_err_o(cfg_crc_err_o), .cfg_applied_o(cfg_applied_o));
	sic_pin_model pins (.core_clk_i(core_clk_i), .lvl_i(lvl), .tp_i(tp), .safe_in_o(safe_in_i));

	// ************************************************
	// helpers
	// ************************************************
	task automatic results();
		if (miscompares == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic note(input bit bad, input string what);
		check_count++;
		if (bad) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask
	task automatic chk_out(input logic [31:0] got, input logic [31:0] exp, input string what);
		note(got !== exp, what);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic pin(input logic [5:0] v);
		@(posedge core_clk_i);
		lvl <= v;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		note(reg_rdata_o !== exp, "read data");
	endtask
	function automatic logic [15:0] crc(input logic [95:0] d);
		logic [15:0] c = 16'hffff;
		for (int i = 95; i >= 0; i--) begin
			c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
		end
		return c;
	endfunction
	function automatic logic [31:0] cw(int cons, int deb, bit rt, bit md, bit ty, bit en);
		return {16'(cons), 8'(deb), 4'h0, rt, md, ty, en};
	endfunction
	task automatic commit(input logic [15:0] bad);
		for (int g = 0; g < 3; g++) begin
			wr(8'(4 * g), cfg[g]);
		end
		wr(SIC_ADR_CRC, {16'h0, crc({cfg[2], cfg[1], cfg[0]}) ^ bad});
		wr(SIC_ADR_CTRL, 32'h1);
		cyc(2);
	endtask
	// output bit b keeps its old value for lo cycles and reaches v by hi cycles
	task automatic edge_win(input int b, input bit v, input int lo, input int hi);
		int n = 0;
		cyc(lo);
		chk_out(safe_val_o[b], !v, "early change");
		while (safe_val_o[b] !== v && n < hi - lo) begin
			cyc(1);
			n++;
		end
		chk_out(safe_val_o[b], v, "late change");
	endtask

	// ************************************************
	// tests
	// ************************************************
	initial begin
		void'($urandom(32'hd951ca07));
		repeat (20) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		cyc(1);
		chk_out({cfg_applied_o, cfg_crc_err_o, cons_err_o, line_err_o, safe_val_o}, 32'h0, "reset");
		rd(SIC_ADR_ACT0, 32'h0);
		rd(8'h24, 32'h0);
		cfg[0] = cw(0, 2, 0, 0, 0, 1);
		cfg[1] = cw(10, 0, 0, 1, 0, 1);
		cfg[2] = cw(0, 0, 1, 0, 1, 0);
		commit(16'h0100);
		chk_out({cfg_crc_err_o, cfg_applied_o}, 32'h2, "bad crc taken");
		rd(SIC_ADR_ACT1, 32'h0);
		commit(16'h0);
		act = cfg;
		chk_out({cfg_crc_err_o, cfg_applied_o}, 32'h1, "good crc refused");
		for (int g = 0; g < 3; g++) begin
			rd(8'(SIC_ADR_ACT0 + 4 * g), act[g]);
		end
		// single line debounce
		pin(6'h01);
		cyc($urandom_range(1, 12));
		pin(6'h00);
		cyc(40);
		chk_out(safe_val_o, 32'h0, "short burst passed");
		pin(6'h31);
		edge_win(0, 1'b1, 20, 36);
		chk_out(safe_val_o, 32'h01, "line values");
		pin(6'h30);
		cyc($urandom_range(1, 4));
		pin(6'h31);
		cyc(20);
		chk_out(safe_val_o[0], 32'h1, "short dip passed");
		pin(6'h30);
		edge_win(0, 1'b0, 8, 24);
		// dual pair
		pin(6'h0c);
		edge_win(2, 1'b1, 12, 30);
		chk_out(safe_val_o[3], 32'h1, "pair copy");
		pin(6'h04);
		cyc(30);
		chk_out({cons_err_o, safe_val_o[3:2]}, 32'h0, "pair mismatch");
		cyc(40);
		chk_out(cons_err_o, 32'h2, "pair error");
		pin(6'h0c);
		cyc(80);
		chk_out({cons_err_o, safe_val_o[3:2]}, 32'h08, "error held");
		wr(SIC_ADR_CTRL, 32'h2);
		cyc(70);
		chk_out({cons_err_o, safe_val_o[3:2]}, 32'h03, "error reset");
		// contact inputs, only line 4 sees test pulses
		cfg[2] = cw(0, 0, 1, 0, 1, 1);
		commit(16'h0);
		act = cfg;
		pin(6'h3c);
		cyc(100);
		chk_out({line_err_o, safe_val_o[5:4]}, {24'h0, 6'h20, 2'b01}, "test pulses");
		rd(SIC_ADR_STAT, {15'h0, 1'b1, 1'b0, 6'h20, 3'h0, 6'h1c});
		rd(SIC_ADR_ACT2, act[2]);
		results();
	end

	initial begin
		#(25 * 4000);
		miscompares++;
		results();
	end
endmodule
